// ==== bst_defs.vh ====
`ifndef BST_DEFS_VH
`define BST_DEFS_VH

// ----------------------------------------------------------------
// instruction register
// ----------------------------------------------------------------
`define BST_IR_W 6
`define BST_OP_EXTEST 6'h00
`define BST_OP_SAMPLE 6'h01
`define BST_OP_IDCODE 6'h02
`define BST_OP_HIGHZ 6'h03
`define BST_OP_CLAMP 6'h3e
`define BST_OP_BYPASS 6'h3f
`define BST_IR_CAPTURE 6'h2d

// ----------------------------------------------------------------
// identification register (value arbitrary, bit 0 must be one)
// ----------------------------------------------------------------
`define BST_ID_W 32
`define BST_ID_VALUE 32'h0a5c_3e01

// ----------------------------------------------------------------
// boundary chain layout
// ----------------------------------------------------------------
`define BST_IN_N 8
`define BST_IO_N 4
`define BST_CHAIN_W 16

// ----------------------------------------------------------------
// sample buffer
// ----------------------------------------------------------------
`define BST_FIFO_W 2
`define BST_FIFO_DEPTH 16
`define BST_FIFO_AW 4

`endif

// ==== bst_tap.v ====
`timescale 1ns/1ns
`include "bst_defs.vh"

// ----------------------------------------------------------------
// sample buffer
// ----------------------------------------------------------------
module bst_fifo #(
   parameter W = `BST_FIFO_W,
   parameter DEPTH = `BST_FIFO_DEPTH,
   parameter AW = `BST_FIFO_AW
) (
   // clock and reset
   input wire core_clk_i,
   input wire rstn_i,
   input wire ce_i,
   // fill side
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [W-1:0] in_data_i,
   // drain side
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [W-1:0] out_data_o
);
   reg [W-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0] wr_q;
   reg [AW-1:0] rd_q;
   reg [AW:0] cnt_q;
   wire push, pop;
   integer i;
   assign in_ready_o = (cnt_q != DEPTH[AW:0]);
   assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
   assign out_data_o = mem_q[rd_q];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   always @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wr_q <= {AW{1'b0}};
         rd_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
         for (i = 0; i < DEPTH; i = i + 1) begin
            mem_q[i] <= {W{1'b0}};
         end
      end else if (ce_i) begin
         if (push) begin
            mem_q[wr_q] <= in_data_i;
            wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
         end else if (pop && !push) begin
            cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
         end
      end
   end
endmodule // bst_fifo

// Operation
// - sixteen-state controller, six-bit instruction register
// - five test pins: reset, clock, mode select, data in, data out
// - low test reset forces Test-Logic-Reset asynchronously
// - mode select and data in are taken on test clock rising edge
// - data out changes on test clock falling edge
// - data out enabled only in Shift-DR and Shift-IR
// - state advances by mode select captured at each rising edge
// - five cycles of mode select high reach Test-Logic-Reset
// - data in feeds boundary chain, instruction, identity or bypass
// - reset, mode select and data in read high when undriven
// - boundary chain tests interconnect of the dc-coupled pins
// - no ac-coupled test mode with time-varying stimulus
// - identification register readable through the controller
// - opcodes: extest 000000, sample 000001, idcode 000010, bypass 111111
// - Capture-IR loads 101101
// - shifted instruction takes effect only at Update-IR
// - 000011 tristates all pin outputs; 111111 gives one-bit bypass
module bst_tap (
   // clock, reset, enable
   input wire core_clk_i,
   input wire rstn_i,
   input wire ce_i,
   // test port pins
   input wire tck_i,
   input wire tms_i,
   input wire tdi_i,
   input wire trst_n_i,
   output wire tdo_o,
   output wire tdo_oe_o,
   // sample buffer fill ready
   output wire link_ready_o,
   // dc-coupled pads
   input wire [`BST_IN_N-1:0] pad_in_i,
   input wire [`BST_IO_N-1:0] pad_io_i,
   output wire [`BST_IO_N-1:0] pad_io_o,
   output wire [`BST_IO_N-1:0] pad_io_oe_o,
   // core side of the pads
   output wire [`BST_IN_N-1:0] core_in_o,
   output wire [`BST_IO_N-1:0] core_io_in_o,
   input wire [`BST_IO_N-1:0] core_io_i,
   input wire [`BST_IO_N-1:0] core_io_oe_i
);
   // ----------------------------------------------------------------
   // controller states
   // ----------------------------------------------------------------
   localparam S_TLR = 16'h0001;
   localparam S_RTI = 16'h0002;
   localparam S_SELDR = 16'h0004;
   localparam S_CAPDR = 16'h0008;
   localparam S_SHDR = 16'h0010;
   localparam S_EX1DR = 16'h0020;
   localparam S_PSDR = 16'h0040;
   localparam S_EX2DR = 16'h0080;
   localparam S_UPDR = 16'h0100;
   localparam S_SELIR = 16'h0200;
   localparam S_CAPIR = 16'h0400;
   localparam S_SHIR = 16'h0800;
   localparam S_EX1IR = 16'h1000;
   localparam S_PSIR = 16'h2000;
   localparam S_EX2IR = 16'h4000;
   localparam S_UPIR = 16'h8000;
   localparam SYNC_W = 3 + `BST_IN_N + `BST_IO_N;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   reg [SYNC_W-1:0] sync1_q;
   reg [SYNC_W-1:0] sync2_q;
   reg tck_prev_q, trst1_q, trst2_q;
   wire trst_raw_n, tap_rst_n, tck_s, tms_s, tdi_s, tck_rise, tck_fall;
   wire [`BST_IN_N-1:0] pad_in_s;
   wire [`BST_IO_N-1:0] pad_io_s;
   // undriven tms and tdi settle high, matching the pad pull-ups; tck and pads start low
   always @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync1_q <= {{(SYNC_W-2){1'b0}}, 2'b11};
         sync2_q <= {{(SYNC_W-2){1'b0}}, 2'b11};
         tck_prev_q <= 1'b0;
      end else if (ce_i) begin
         sync1_q <= {pad_io_i, pad_in_i, tck_i, tms_i, tdi_i};
         sync2_q <= sync1_q;
         tck_prev_q <= tck_s;
      end
   end

   assign tdi_s = sync2_q[0];
   assign tms_s = sync2_q[1];
   assign tck_s = sync2_q[2];
   assign pad_in_s = sync2_q[3 +: `BST_IN_N];
   assign pad_io_s = sync2_q[3 + `BST_IN_N +: `BST_IO_N];
   assign tck_rise = tck_s & ~tck_prev_q;
   assign tck_fall = ~tck_s & tck_prev_q;

   // test reset asserts at once, releases through two flops
   assign trst_raw_n = rstn_i & trst_n_i;
   always @(posedge core_clk_i or negedge trst_raw_n) begin
      if (!trst_raw_n) begin
         trst1_q <= 1'b0;
         trst2_q <= 1'b0;
      end else if (ce_i) begin
         trst1_q <= 1'b1;
         trst2_q <= trst1_q;
      end
   end
   assign tap_rst_n = rstn_i & trst2_q;

   // ----------------------------------------------------------------
   // rising-edge samples buffered ahead of the controller
   // ----------------------------------------------------------------
   wire fifo_in_ready, fifo_out_valid, fifo_out_ready;
   wire [`BST_FIFO_W-1:0] fifo_out_data;
   reg link_ready_q, fall_pend_q;
   wire step, tms_t, tdi_t;
   bst_fifo #(
      .W(`BST_FIFO_W),
      .DEPTH(`BST_FIFO_DEPTH),
      .AW(`BST_FIFO_AW)
   ) u_fifo (
      .core_clk_i(core_clk_i),
      .rstn_i(tap_rst_n),
      .ce_i(ce_i),
      .in_valid_i(tck_rise),
      .in_ready_o(fifo_in_ready),
      .in_data_i({tms_s, tdi_s}),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_out_ready),
      .out_data_o(fifo_out_data)
   );

   // drain holds until the falling edge has published the last step
   assign fifo_out_ready = ~fall_pend_q;
   assign step = fifo_out_valid & fifo_out_ready & ce_i;
   assign tms_t = fifo_out_data[1];
   assign tdi_t = fifo_out_data[0];

   always @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         link_ready_q <= 1'b0;
      end else if (ce_i) begin
         link_ready_q <= fifo_in_ready;
      end
   end
   assign link_ready_o = link_ready_q;

   // ----------------------------------------------------------------
   // controller next state
   // ----------------------------------------------------------------
   reg [15:0] state_q;
   reg [15:0] state_d;
   always @* begin
      state_d = S_TLR;
      case (state_q)
         S_TLR: state_d = tms_t ? S_TLR : S_RTI;
         S_RTI: state_d = tms_t ? S_SELDR : S_RTI;
         S_SELDR: state_d = tms_t ? S_SELIR : S_CAPDR;
         S_CAPDR: state_d = tms_t ? S_EX1DR : S_SHDR;
         S_SHDR: state_d = tms_t ? S_EX1DR : S_SHDR;
         S_EX1DR: state_d = tms_t ? S_UPDR : S_PSDR;
         S_PSDR: state_d = tms_t ? S_EX2DR : S_PSDR;
         S_EX2DR: state_d = tms_t ? S_UPDR : S_SHDR;
         S_UPDR: state_d = tms_t ? S_SELDR : S_RTI;
         // five highs from any state end here
         S_SELIR: state_d = tms_t ? S_TLR : S_CAPIR;
         S_CAPIR: state_d = tms_t ? S_EX1IR : S_SHIR;
         S_SHIR: state_d = tms_t ? S_EX1IR : S_SHIR;
         S_EX1IR: state_d = tms_t ? S_UPIR : S_PSIR;
         S_PSIR: state_d = tms_t ? S_EX2IR : S_PSIR;
         S_EX2IR: state_d = tms_t ? S_UPIR : S_SHIR;
         S_UPIR: state_d = tms_t ? S_SELDR : S_RTI;
         default: state_d = S_TLR;
      endcase
   end

   // ----------------------------------------------------------------
   // instruction decode
   // ----------------------------------------------------------------
   reg [`BST_IR_W-1:0] ir_sh_q;
   reg [`BST_IR_W-1:0] ir_q;
   wire op_extest, op_sample, op_idcode, op_highz, op_clamp;
   wire sel_bnd, test_drive;
   assign op_extest = (ir_q == `BST_OP_EXTEST);
   assign op_sample = (ir_q == `BST_OP_SAMPLE);
   assign op_idcode = (ir_q == `BST_OP_IDCODE);
   assign op_highz = (ir_q == `BST_OP_HIGHZ);
   assign op_clamp = (ir_q == `BST_OP_CLAMP);
   assign sel_bnd = op_extest | op_sample;
   // other opcodes, bypass and reserved alike, leave pins alone, except highz, which disables every pin output
   assign test_drive = op_extest | op_clamp;

   // ----------------------------------------------------------------
   // boundary cells: inputs first, then enable/data pair per i/o pin
   // ----------------------------------------------------------------
   reg [`BST_CHAIN_W-1:0] bnd_sh_q;
   reg [`BST_CHAIN_W-1:0] bnd_up_q;
   reg [`BST_IO_N-1:0] pad_io_q, pad_io_oe_q, core_io_in_q;
   reg [`BST_IN_N-1:0] core_in_q;
   wire [`BST_CHAIN_W-1:0] bnd_cap;
   wire [`BST_IO_N-1:0] io_data_d, io_oe_d;
   // only dc-coupled pins have cells; no ac stimulus exists here
   assign bnd_cap[`BST_IN_N-1:0] = pad_in_s;

   genvar k;
   generate
      for (k = 0; k < `BST_IO_N; k = k + 1) begin : g_io
         // data cell sees the core when driving in mission mode
         assign bnd_cap[`BST_IN_N + 2*k] = core_io_oe_i[k];
         assign bnd_cap[`BST_IN_N + 2*k + 1] =
            (core_io_oe_i[k] & ~op_extest) ? core_io_i[k] : pad_io_s[k];
         assign io_oe_d[k] = op_highz ? 1'b0 :
            (test_drive ? bnd_up_q[`BST_IN_N + 2*k] : core_io_oe_i[k]);
         assign io_data_d[k] = test_drive ?
            bnd_up_q[`BST_IN_N + 2*k + 1] : core_io_i[k];
      end
   endgenerate

   always @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pad_io_q <= {`BST_IO_N{1'b0}};
         pad_io_oe_q <= {`BST_IO_N{1'b0}};
         core_in_q <= {`BST_IN_N{1'b0}};
         core_io_in_q <= {`BST_IO_N{1'b0}};
      end else if (ce_i) begin
         pad_io_q <= io_data_d;
         pad_io_oe_q <= io_oe_d;
         core_in_q <= pad_in_s;
         core_io_in_q <= pad_io_s;
      end
   end

   assign pad_io_o = pad_io_q;
   assign pad_io_oe_o = pad_io_oe_q;
   assign core_in_o = core_in_q;
   assign core_io_in_o = core_io_in_q;

   // ----------------------------------------------------------------
   // controller, data registers and serial output
   // ----------------------------------------------------------------
   reg bypass_q, tdo_q, tdo_oe_q;
   reg [`BST_ID_W-1:0] id_q;
   wire dr_out;
   assign dr_out = sel_bnd ? bnd_sh_q[0] :
      (op_idcode ? id_q[0] : bypass_q);

   always @(posedge core_clk_i or negedge tap_rst_n) begin
      if (!tap_rst_n) begin
         state_q <= S_TLR;
         ir_sh_q <= {`BST_IR_W{1'b0}};
         ir_q <= `BST_OP_IDCODE;
         bypass_q <= 1'b0;
         id_q <= {`BST_ID_W{1'b0}};
         bnd_sh_q <= {`BST_CHAIN_W{1'b0}};
         bnd_up_q <= {`BST_CHAIN_W{1'b0}};
         tdo_q <= 1'b0;
         tdo_oe_q <= 1'b0;
         fall_pend_q <= 1'b0;
      end else if (ce_i) begin
         if (step) begin
            state_q <= state_d;
            fall_pend_q <= 1'b1;
            case (state_q)
               S_TLR: ir_q <= `BST_OP_IDCODE;
               S_CAPIR: ir_sh_q <= `BST_IR_CAPTURE;
               S_SHIR: ir_sh_q <= {tdi_t, ir_sh_q[`BST_IR_W-1:1]};
               S_CAPDR: begin
                  bypass_q <= 1'b0;
                  if (sel_bnd) begin
                     bnd_sh_q <= bnd_cap;
                  end
                  if (op_idcode) begin
                     id_q <= `BST_ID_VALUE;
                  end
               end
               S_SHDR: begin
                  if (sel_bnd) begin
                     bnd_sh_q <= {tdi_t, bnd_sh_q[`BST_CHAIN_W-1:1]};
                  end else if (op_idcode) begin
                     id_q <= {tdi_t, id_q[`BST_ID_W-1:1]};
                  end else begin
                     bypass_q <= tdi_t;
                  end
               end
               default: ;
            endcase
         end else if (tck_fall) begin
            fall_pend_q <= 1'b0;
            tdo_q <= state_q[11] ? ir_sh_q[0] : dr_out;
            tdo_oe_q <= state_q[4] | state_q[11];
            if (state_q == S_UPIR) begin
               ir_q <= ir_sh_q;
            end
            if ((state_q == S_UPDR) && sel_bnd) begin
               bnd_up_q <= bnd_sh_q;
            end
         end
      end
   end

   assign tdo_o = tdo_q;
   assign tdo_oe_o = tdo_oe_q;
endmodule // bst_tap

// ==== bst_tap_monitor.sv ====
`timescale 1ns/1ns
`include "bst_defs.vh"
// ----
// port checker
// ----
module bst_tap_monitor (
   // clock and resets
   input wire core_clk_i,
   input wire rstn_i,
   input wire trst_n_i,
   // watched ports
   input wire tck_i,
   input wire tdo_o,
   input wire tdo_oe_o,
   input wire link_ready_o,
   input wire [`BST_IN_N-1:0] pad_in_i,
   input wire [`BST_IN_N-1:0] core_in_o,
   input wire [`BST_IO_N-1:0] pad_io_i,
   input wire [`BST_IO_N-1:0] core_io_in_o
);
   // sync stages still fill for a few cycles after reset
   reg [2:0] up_q;
   always @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         up_q <= 3'h0;
      end else if (up_q != 3'h7) begin
         up_q <= up_q + 3'h1;
      end
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);
   chk_trst_quiet: assert property (!trst_n_i |-> !tdo_oe_o)
      else $error("tdo enabled in test reset");
   chk_tdo_fall: assert property (
      $changed(tdo_o) && trst_n_i && $past(trst_n_i) |-> !$past(tck_i, 2))
      else $error("tdo moved outside a tck fall");
   chk_oe_fall: assert property (
      $changed(tdo_oe_o) && trst_n_i && $past(trst_n_i)
      |-> !$past(tck_i, 2))
      else $error("tdo enable moved outside a tck fall");
   chk_tdo_hold: assert property (tck_i [*5] |-> $stable(tdo_o))
      else $error("tdo moved while tck high");
   chk_oe_span: assert property (disable iff (!rstn_i || !trst_n_i)
      $rose(tdo_oe_o) |-> tdo_oe_o [*8])
      else $error("tdo enable shorter than a shift");
   chk_core_in: assert property (
      (up_q == 3'h7 && $stable(pad_in_i)) [*5] |-> core_in_o == pad_in_i)
      else $error("core input not following pad");
   chk_io_in: assert property (
      (up_q == 3'h7 && $stable(pad_io_i)) [*5] |-> core_io_in_o == pad_io_i)
      else $error("core io input not following pad");
   chk_ready_up: assert property (
      up_q == 3'h7 && trst_n_i && $past(trst_n_i, 2) |-> link_ready_o)
      else $error("sample buffer refused a tck sample");
   cov_shift: cover property ($rose(tdo_oe_o));
   cov_trst: cover property ($fell(trst_n_i));
   cov_tck_high: cover property (tck_i [*5]);
endmodule // bst_tap_monitor

bind bst_tap bst_tap_monitor u_mon (.core_clk_i(core_clk_i),
   .rstn_i(rstn_i), .trst_n_i(trst_n_i), .tck_i(tck_i), .tdo_o(tdo_o),
   .tdo_oe_o(tdo_oe_o), .link_ready_o(link_ready_o),
   .pad_in_i(pad_in_i), .core_in_o(core_in_o), .pad_io_i(pad_io_i),
   .core_io_in_o(core_io_in_o));

// ==== bst_tester.sv ====
`timescale 1ns/1ns
// ----
// boundary-scan tester model
// ----
module bst_tester (
   // test port
   output logic tck_o,
   output logic tms_o,
   output logic tdi_o,
   input wire logic tdo_i,
   input wire logic tdo_oe_i
);
   logic oe_ok;
   // tck rests low between frames, lines at pull-up level
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b1;
      oe_ok = 1'b1;
   end
   // one 125 ns period; tdo taken just before the rise
   task automatic step(input logic m, input logic d, output logic [1:0] q);
      tms_o = m;
      tdi_o = d;
      #62;
      q = {tdo_oe_i, tdo_i};
      tck_o = 1'b1;
      #63;
      tck_o = 1'b0;
   endtask
   // frames start off the core clock grid so no tck edge races it
   task automatic reset5;
      logic [1:0] q;
      #(12 - $time % 10);
      repeat (5) step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
   endtask
   // idle to idle through one scan of n bits, lsb first
   task automatic scan(input logic ir, input int n, input logic [47:0] din,
                       output logic [47:0] dout);
      logic [1:0] q;
      dout = 48'h0;
      oe_ok = 1'b1;
      #(12 - $time % 10);
      step(1'b1, 1'b1, q);
      if (ir) step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
      step(1'b0, 1'b1, q);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         dout[i] = q[0];
         oe_ok &= q[1];
      end
      step(1'b1, 1'b1, q);
      oe_ok &= !q[1];
      step(1'b0, 1'b1, q);
      tms_o = 1'b1;
   endtask
endmodule // bst_tester

// ==== bst_tap_tb.sv ====
`timescale 1ns/1ns
`include "bst_defs.vh"
module bst_tap_tb;
   logic core_clk, rstn, trst_n, ce;
   logic [7:0] pad_in;
   logic [3:0] ext_io, core_io, core_io_oe;
   wire tck, tms, tdi, tdo, tdo_oe, rdy;
   wire [3:0] pad_io, pad_out, pad_oe, core_io_in;
   wire [7:0] core_in;
   int err_total, n_tests;
   // wire level: pad where it drives, board level elsewhere
   assign pad_io = (pad_oe & pad_out) | (~pad_oe & ext_io);
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   bst_tap dut (.core_clk_i(core_clk), .rstn_i(rstn), .ce_i(ce),
      .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .trst_n_i(trst_n),
      .tdo_o(tdo), .tdo_oe_o(tdo_oe), .link_ready_o(rdy),
      .pad_in_i(pad_in), .pad_io_i(pad_io), .pad_io_o(pad_out),
      .pad_io_oe_o(pad_oe), .core_in_o(core_in),
      .core_io_in_o(core_io_in), .core_io_i(core_io),
      .core_io_oe_i(core_io_oe));
   bst_tester u_tst (.tck_o(tck), .tms_o(tms), .tdi_o(tdi),
      .tdo_i(tdo), .tdo_oe_i(tdo_oe));
   // ----
   // checking
   // ----
   task automatic check(input string what, input logic [47:0] seen,
                        input logic [47:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic sc(input logic ir, input int n, input logic [47:0] d,
                     output logic [47:0] o);
      u_tst.scan(ir, n, d, o);
      check("tdo enable", 48'(u_tst.oe_ok), 48'h1);
   endtask
   task automatic ld_ir(input logic [5:0] op);
      logic [47:0] o;
      sc(1'b1, 6, 48'(op), o);
      check("ir capture", o, 48'(`BST_IR_CAPTURE));
   endtask
   // ----
   // scenarios
   // ----
   task automatic t_idcode;
      logic [47:0] o;
      check("tdo enable idle", 48'(tdo_oe), 48'h0);
      sc(1'b0, 32, 48'h0, o);
      check("idcode", o, 48'(`BST_ID_VALUE));
      $display("t_idcode done");
   endtask
   task automatic t_opcodes;
      logic [5:0] ops [9] = '{6'h01, 6'h00, 6'h02, 6'h03, 6'h3e, 6'h3f,
                              6'h04, 6'h2c, 6'h3d};
      logic [47:0] o;
      int len;
      @(posedge core_clk) pad_in <= 8'h5a;
      foreach (ops[i]) begin
         ld_ir(ops[i]);
         len = ops[i] < 6'h02 ? 16 : ops[i] == 6'h02 ? 32 : 1;
         sc(1'b0, 48, 48'h1, o);
         check("path length", o >> len, 48'h1);
         if (len == 16) check("input cells", 48'(o[7:0]), 48'h5a);
         if (len == 32) check("id", 48'(o[31:0]), `BST_ID_VALUE);
         check("pad enable", 48'(pad_oe),
            (ops[i] == 6'h00 || ops[i] == 6'h03 || ops[i] == 6'h3e) ?
            48'h0 : 48'h5);
      end
      $display("t_opcodes done");
   endtask
   task automatic t_extest;
      logic [47:0] o;
      @(posedge core_clk) pad_in <= 8'h3c;
      ld_ir(6'h01);
      sc(1'b0, 16, 48'hf700, o);
      check("mission pads", 48'({pad_oe, pad_out}), 48'h56);
      ld_ir(6'h00);
      check("extest drive", 48'({pad_oe, pad_out}), 48'hfd);
      sc(1'b0, 16, 48'hf700, o);
      check("extest capture", o & 48'haaff, 48'ha23c);
      ld_ir(6'h03);
      check("highz pads", 48'(pad_oe), 48'h0);
      ld_ir(6'h3f);
      check("bypass pads", 48'(pad_oe), 48'h5);
      $display("t_extest done");
   endtask
   task automatic t_tms_reset;
      logic [47:0] o;
      ld_ir(6'h3f);
      u_tst.reset5;
      sc(1'b0, 32, 48'h0, o);
      check("id after tms reset", o, 48'(`BST_ID_VALUE));
      $display("t_tms_reset done");
   endtask
   task automatic t_trst;
      logic [47:0] o;
      logic [1:0] q;
      ld_ir(6'h3f);
      u_tst.step(1'b1, 1'b1, q);
      u_tst.step(1'b0, 1'b1, q);
      u_tst.step(1'b0, 1'b1, q);
      u_tst.step(1'b0, 1'b1, q);
      check("tdo enable shift", 48'(tdo_oe), 48'h1);
      @(posedge core_clk) trst_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      check("tdo enable reset", 48'(tdo_oe), 48'h0);
      trst_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      // keep pin changes off the core edge
      #2;
      u_tst.step(1'b0, 1'b1, q);
      sc(1'b0, 32, 48'h0, o);
      check("id after test reset", o, 48'(`BST_ID_VALUE));
      $display("t_trst done");
   endtask
   // a tck pulse while frozen must not move the controller out of idle
   task automatic t_freeze;
      logic [47:0] o;
      logic [1:0] q;
      @(posedge core_clk) ce <= 1'b0;
      #2;
      u_tst.step(1'b1, 1'b1, q);
      @(posedge core_clk) ce <= 1'b1;
      check("tdo enable frozen", 48'(tdo_oe), 48'h0);
      sc(1'b0, 32, 48'h0, o);
      check("id after freeze", o, 48'(`BST_ID_VALUE));
      $display("t_freeze done");
   endtask
   initial begin
      repeat (100000) @(posedge core_clk);
      err_total++;
      print_verdict;
   end
   initial begin
      rstn = 1'b0;
      trst_n = 1'b1;
      ce = 1'b1;
      pad_in = 8'ha5;
      ext_io = 4'h3;
      core_io = 4'h6;
      core_io_oe = 4'h5;
      err_total = 0;
      n_tests = 0;
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (4) @(posedge core_clk);
      u_tst.reset5;
      t_idcode;
      t_opcodes;
      t_extest;
      t_tms_reset;
      t_trst;
      t_freeze;
      print_verdict;
   end
endmodule // bst_tap_tb
